// *** hw/eil_top.sv ***
// External interrupt latch: pin edge/level request with mask and acknowledge
//
// Behaviour
// - Falling edge on request pin sets the latch in both modes.
// - Vector fetch acknowledge clears the latch that caused the fetch.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and mode bit, even with pin held low.
// - Edge mode: any acknowledge clears the latch at once.
// - Level mode: clear needs acknowledge and pin high, either order.
// - Level mode: request stays pending while the pin is low.
// - Mask bit set withholds the request from priority logic.
// - CPU global interrupt mask also blocks the request.
// - Acknowledge write does not block later falling edges.
// - Taken request vectors the CPU through VECTOR_HI_ADDR only, held fixed on the vector output.
// - Pending flag reads latch state, independent of mask.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - Mask bit read/write, reset clear, one disables requests.
// - Mode bit read/write, reset clear, one adds low-level sensing.
// - In break with clear enable low, acknowledge writes are ignored.
// - In break with clear enable high, writes clear and stay cleared.
// - Status/control: pending 3, ack 2, mask 1, mode 0, upper zero.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module eil_top (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    // Wishbone slave
    input  wire logic                        i_wb_cyc,
    input  wire logic                        i_wb_stb,
    input  wire logic                        i_wb_we,
    input  wire logic [eil_pkg::ADR_W-1:0]   i_wb_adr,
    input  wire logic [eil_pkg::DAT_W-1:0]   i_wb_dat,
    input  wire logic [3:0]                  i_wb_sel,
    output logic      [eil_pkg::DAT_W-1:0]   o_wb_dat,
    output logic                             o_wb_ack,
    // External request pin, active low
    input  wire logic                        i_request_n,
    // CPU side
    input  wire logic                        i_vector_fetch,
    input  wire logic                        i_global_mask,
    output logic                             o_cpu_request,
    output logic      [15:0]                 o_vector_addr,
    // Break state control
    input  wire logic                        i_break_state,
    input  wire logic                        i_break_clear_enable,
    // Event interrupt
    output logic                             o_int
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helper

    // True when the indexed register is the wanted one
    function automatic logic reg_sel(
        input logic [eil_pkg::IDX_W-1:0] idx,
        input logic [eil_pkg::IDX_W-1:0] target
    );
        reg_sel = (idx == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    eil_regbus_if rb ();

    logic                       pin;
    logic                       pin_prev;
    logic                       next_pin_prev;
    logic                       fall;
    logic                       low;

    eil_pkg::eil_latch_t        state;
    eil_pkg::eil_latch_t        next_state;

    logic                       mode;
    logic                       mask;
    logic                       next_mode;
    logic                       next_mask;

    logic [eil_pkg::EV_W-1:0]   event_flags;
    logic [eil_pkg::EV_W-1:0]   event_en;
    logic [eil_pkg::EV_W-1:0]   next_event_flags;
    logic [eil_pkg::EV_W-1:0]   next_event_en;
    logic [eil_pkg::EV_W-1:0]   ev_set;

    logic                       cpu_request;
    logic                       next_cpu_request;
    logic                       int_out;
    logic                       next_int_out;
    logic [15:0]                vector_addr;
    logic [15:0]                next_vector_addr;

    logic                       wr_ctl;
    logic                       wr_event;
    logic                       wr_event_en;
    logic                       sw_ack;
    logic                       break_block;
    logic                       ack;
    logic                       pending;
    logic                       next_pending;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    // Pin synchroniser
    eil_sync u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_request_n),
        .o_sync  (pin)
    );

    // Bus slave
    eil_wb_slave u_wb (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_wb_cyc (i_wb_cyc),
        .i_wb_stb (i_wb_stb),
        .i_wb_we  (i_wb_we),
        .i_wb_adr (i_wb_adr),
        .i_wb_dat (i_wb_dat),
        .i_wb_sel (i_wb_sel),
        .o_wb_dat (o_wb_dat),
        .o_wb_ack (o_wb_ack),
        .rb       (rb)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling

    // Edge detect on the synchronised level only
    assign next_pin_prev = pin;
    assign fall          = pin_prev & ~pin;
    assign low           = ~pin;

    // Register previous pin level
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_prev <= ~eil_pkg::RST_PIN;
        end else begin
            pin_prev <= next_pin_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode and acknowledge sources

    // Register write strobes
    always_comb begin
        wr_ctl      = rb.wr & reg_sel(rb.idx, eil_pkg::IDX_STATUS_CONTROL);
        wr_event    = rb.wr & reg_sel(rb.idx, eil_pkg::IDX_EVENT);
        wr_event_en = rb.wr & reg_sel(rb.idx, eil_pkg::IDX_EVENT_EN);
    end

    // Software acknowledge, a write of one to the ack bit
    assign sw_ack = wr_ctl & rb.wdata[eil_pkg::BIT_ACK];

    // Break state blocks software acknowledge unless clear enable is set
    assign break_block = i_break_state & ~i_break_clear_enable;

    // Combined acknowledge; fetch only acts on a latched request
    assign ack = (i_vector_fetch & pending)
               | (sw_ack & ~break_block);

    ////////////////////////////////////////////////////////////////////////
    // Request latch

    // Latch state: idle, pending, acknowledged but pin still low
    always_comb begin
        next_state = state;
        unique case (state)
            eil_pkg::EIL_IDLE: begin
                if (fall) begin
                    next_state = eil_pkg::EIL_PEND;
                end else if (mode && low) begin
                    next_state = eil_pkg::EIL_PEND;
                end
            end
            eil_pkg::EIL_PEND: begin
                if (fall) begin
                    next_state = eil_pkg::EIL_PEND;
                end else if (ack && mode && low) begin
                    next_state = eil_pkg::EIL_WAIT_HIGH;
                end else if (ack) begin
                    next_state = eil_pkg::EIL_IDLE;
                end
            end
            eil_pkg::EIL_WAIT_HIGH: begin
                if (!low || !mode) begin
                    next_state = eil_pkg::EIL_IDLE;
                end
            end
            default: begin
                next_state = eil_pkg::EIL_IDLE;
            end
        endcase
    end

    // Latch state register, reset drops any request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= eil_pkg::EIL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pending whenever the latch holds a request
    assign pending      = (state != eil_pkg::EIL_IDLE);
    assign next_pending = (next_state != eil_pkg::EIL_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Control bits

    // Mode and mask follow writes to the status/control register
    always_comb begin
        next_mode = mode;
        next_mask = mask;
        if (wr_ctl) begin
            next_mode = rb.wdata[eil_pkg::BIT_MODE];
            next_mask = rb.wdata[eil_pkg::BIT_MASK];
        end
    end

    // Control registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode <= eil_pkg::RST_MODE;
            mask <= eil_pkg::RST_MASK;
        end else begin
            mode <= next_mode;
            mask <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CPU request and vector

    // Present latched request only when neither mask is set
    always_comb begin
        next_cpu_request = next_pending
                         & ~next_mask
                         & ~i_global_mask;
        next_vector_addr = eil_pkg::VECTOR_HI_ADDR;
    end

    // CPU side registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cpu_request <= 1'b0;
            vector_addr <= eil_pkg::VECTOR_HI_ADDR;
        end else begin
            cpu_request <= next_cpu_request;
            vector_addr <= next_vector_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags and interrupt

    // Latch set and latch clear events
    always_comb begin
        ev_set = '0;
        ev_set[eil_pkg::EV_LATCH_SET] = ~pending & next_pending;
        ev_set[eil_pkg::EV_LATCH_CLR] = pending & ~next_pending;
    end

    // Sticky flags, write one to clear, a new event wins
    always_comb begin
        next_event_flags = event_flags;
        next_event_en    = event_en;
        if (wr_event) begin
            next_event_flags = event_flags & ~rb.wdata[eil_pkg::EV_W-1:0];
        end
        next_event_flags = next_event_flags | ev_set;
        if (wr_event_en) begin
            next_event_en = rb.wdata[eil_pkg::EV_W-1:0];
        end
        next_int_out = |(next_event_flags & next_event_en);
    end

    // Event registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            event_flags <= eil_pkg::RST_EVENT;
            event_en    <= eil_pkg::RST_EVENT_EN;
            int_out     <= 1'b0;
        end else begin
            event_flags <= next_event_flags;
            event_en    <= next_event_en;
            int_out     <= next_int_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    // Unmapped indices and unused bits read zero
    always_comb begin
        rb.rdata = '0;
        if (reg_sel(rb.idx, eil_pkg::IDX_STATUS_CONTROL)) begin
            rb.rdata[eil_pkg::BIT_PENDING] = pending;
            rb.rdata[eil_pkg::BIT_ACK]     = 1'b0;
            rb.rdata[eil_pkg::BIT_MASK]    = mask;
            rb.rdata[eil_pkg::BIT_MODE]    = mode;
        end else if (reg_sel(rb.idx, eil_pkg::IDX_EVENT)) begin
            rb.rdata[eil_pkg::EV_W-1:0] = event_flags;
        end else if (reg_sel(rb.idx, eil_pkg::IDX_EVENT_EN)) begin
            rb.rdata[eil_pkg::EV_W-1:0] = event_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_cpu_request = cpu_request;
    assign o_vector_addr = vector_addr;
    assign o_int         = int_out;

endmodule

// *** inc/eil_pkg.sv ***
// Constants and types shared by the external interrupt latch block
package eil_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned IDX_W  = 6;

    ////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_STATUS_CONTROL = 6'h1a;
    localparam logic [5:0] IDX_EVENT          = 6'h1b;
    localparam logic [5:0] IDX_EVENT_EN       = 6'h1c;

    ////////////////////////////////////////////////////////////////////////
    // Status/control field positions
    localparam int unsigned BIT_PENDING = 3;
    localparam int unsigned BIT_ACK     = 2;
    localparam int unsigned BIT_MASK    = 1;
    localparam int unsigned BIT_MODE    = 0;

    // Event field positions, shared by event and event enable registers
    localparam int unsigned EV_W         = 2;
    localparam int unsigned EV_LATCH_SET = 0;
    localparam int unsigned EV_LATCH_CLR = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic            RST_MASK     = 1'b0;
    localparam logic            RST_MODE     = 1'b0;
    localparam logic [EV_W-1:0] RST_EVENT    = 2'h0;
    localparam logic [EV_W-1:0] RST_EVENT_EN = 2'h0;
    localparam logic            RST_PIN      = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Vector locations fetched by the CPU
    localparam logic [15:0] VECTOR_HI_ADDR = 16'hfffa;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'hfffb;

    ////////////////////////////////////////////////////////////////////////
    // Request latch states
    typedef enum logic [2:0] {
        EIL_IDLE      = 3'b001,
        EIL_PEND      = 3'b010,
        EIL_WAIT_HIGH = 3'b100
    } eil_latch_t;

endpackage

// *** inc/eil_regbus_if.sv ***
// Internal register access carrier between bus slave and latch core
`timescale 1ns/1ps
interface eil_regbus_if;
    logic                       wr;     // One-cycle write strobe
    logic [eil_pkg::IDX_W-1:0]  idx;    // Register index
    logic [eil_pkg::REG_W-1:0]  wdata;  // Write data, low byte
    logic [eil_pkg::REG_W-1:0]  rdata;  // Read data of indexed register

    modport bus  (output wr, output idx, output wdata, input rdata);
    modport regs (input wr, input idx, input wdata, output rdata);
endinterface

// *** hw/eil_sync.sv ***
// Two flip-flop synchroniser for the external request pin
`timescale 1ns/1ps
module eil_sync (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Asynchronous pin and synchronised level
    input  wire logic i_async,
    output logic      o_sync
);

    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // Shift the pin through two stages, idle level high
    always_comb begin
        next_stage1 = i_async;
        next_stage2 = stage1;
    end

    // Register the stages, no reset: a pin held low gives no false edge
    always_ff @(posedge i_clock) begin
        stage1 <= next_stage1;
        stage2 <= next_stage2;
    end

    assign o_sync = stage2;

endmodule

// *** hw/eil_wb_slave.sv ***
// Classic Wishbone slave front end for the latch registers
`timescale 1ns/1ps
module eil_wb_slave (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    // Wishbone slave
    input  wire logic                        i_wb_cyc,
    input  wire logic                        i_wb_stb,
    input  wire logic                        i_wb_we,
    input  wire logic [eil_pkg::ADR_W-1:0]   i_wb_adr,
    input  wire logic [eil_pkg::DAT_W-1:0]   i_wb_dat,
    input  wire logic [3:0]                  i_wb_sel,
    output logic      [eil_pkg::DAT_W-1:0]   o_wb_dat,
    output logic                             o_wb_ack,
    // Register side
    eil_regbus_if.bus                        rb
);

    logic                      ack;
    logic [eil_pkg::DAT_W-1:0] dat;
    logic                      next_ack;
    logic [eil_pkg::DAT_W-1:0] next_dat;
    logic                      req;

    // New request: cycle open and no answer given yet
    assign req = i_wb_cyc & i_wb_stb & ~ack;

    // Answer one cycle after the request, drop ack the cycle after
    always_comb begin
        next_ack = req;
        next_dat = '0;
        if (req && !i_wb_we) begin
            next_dat = {{(eil_pkg::DAT_W-eil_pkg::REG_W){1'b0}}, rb.rdata};
        end
    end

    // Register answer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ack <= 1'b0;
            dat <= '0;
        end else begin
            ack <= next_ack;
            dat <= next_dat;
        end
    end

    // Write commits on the edge where the master samples ack
    assign rb.wr    = ack & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0];
    assign rb.idx   = i_wb_adr[eil_pkg::ADR_W-1:2];
    assign rb.wdata = i_wb_dat[eil_pkg::REG_W-1:0];
    assign o_wb_ack = ack;
    assign o_wb_dat = dat;

endmodule

// *** sim/eil_sva.sv ***
// Port-level assertion checker for the external interrupt latch
`timescale 1ns/1ps
module eil_sva (
    // Clock and reset
    input wire logic                      i_clock,
    input wire logic                      i_rst,
    // Wishbone
    input wire logic                      i_wb_cyc,
    input wire logic                      i_wb_stb,
    input wire logic                      i_wb_we,
    input wire logic [eil_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [eil_pkg::DAT_W-1:0] i_wb_dat,
    input wire logic [3:0]                i_wb_sel,
    input wire logic [eil_pkg::DAT_W-1:0] o_wb_dat,
    input wire logic                      o_wb_ack,
    // Pin, CPU side and break
    input wire logic                      i_request_n,
    input wire logic                      i_vector_fetch,
    input wire logic                      i_global_mask,
    input wire logic                      o_cpu_request,
    input wire logic [15:0]               o_vector_addr,
    input wire logic                      i_break_state,
    input wire logic                      i_break_clear_enable,
    input wire logic                      o_int
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of mask and mode, taken from committed writes
    logic sc_wr;
    logic mask_sh;
    logic mode_sh;
    logic next_mask_sh;
    logic next_mode_sh;
    assign sc_wr = o_wb_ack && i_wb_we && i_wb_sel[0]
                   && i_wb_adr[7:2] == eil_pkg::IDX_STATUS_CONTROL;
    always_comb begin
        next_mask_sh = sc_wr ? i_wb_dat[1] : mask_sh;
        next_mode_sh = sc_wr ? i_wb_dat[0] : mode_sh;
    end
    always_ff @(posedge i_clock) begin
        mask_sh <= i_rst ? 1'b0 : next_mask_sh;
        mode_sh <= i_rst ? 1'b0 : next_mode_sh;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    // Properties
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_ans; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_ans: assert property (p_ack_ans) else $error("no bus answer");
    property p_dat_hi; o_wb_dat[31:4] == 28'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper bits set");
    property p_sc_read;
        o_wb_ack && !i_wb_we && i_wb_adr[7:2] == eil_pkg::IDX_STATUS_CONTROL
        |-> o_wb_dat[2:0] == {1'b0, mask_sh, mode_sh};
    endproperty
    a_sc_read: assert property (p_sc_read) else $error("bad ctrl read");
    property p_vec; o_vector_addr == 16'hfffa; endproperty
    a_vec: assert property (p_vec) else $error("bad vector address");
    property p_rst; $fell(i_rst) |-> !o_cpu_request && !o_int && !o_wb_ack;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
    property p_gmask; i_global_mask |=> !o_cpu_request; endproperty
    a_gmask: assert property (p_gmask) else $error("global mask ignored");
    property p_mask; mask_sh && $past(mask_sh) |-> !o_cpu_request; endproperty
    a_mask: assert property (p_mask) else $error("mask ignored");
    property p_fall;
        ($fell(i_request_n) && !i_wb_cyc && !i_vector_fetch && !mask_sh
         && !i_global_mask) ##1 (!i_wb_cyc && !i_vector_fetch
         && !i_global_mask) [*3] |-> o_cpu_request;
    endproperty
    a_fall: assert property (p_fall) else $error("edge not latched");
    property p_sw_ack;
        sc_wr && i_wb_dat[2] && !i_wb_dat[0]
        && !(i_break_state && !i_break_clear_enable)
        |-> ##[1:2] !o_cpu_request;
    endproperty
    a_sw_ack: assert property (p_sw_ack) else $error("ack kept request");
    property p_brk;
        (sc_wr && i_wb_dat[2] && !i_wb_dat[1] && !i_wb_dat[0] && !mode_sh
         && i_break_state && !i_break_clear_enable && o_cpu_request
         && !i_global_mask) ##1 (!i_vector_fetch && !i_global_mask) [*2]
        |-> o_cpu_request;
    endproperty
    a_brk: assert property (p_brk) else $error("break ack cleared");
    property p_level;
        (mode_sh && !mask_sh && !i_request_n && !i_global_mask
         && !i_wb_cyc) [*3] ##0 o_cpu_request |=> o_cpu_request;
    endproperty
    a_level: assert property (p_level) else $error("level dropped");
    // Main scenarios reached
    c_fall: cover property ($fell(i_request_n) ##3 o_cpu_request);
    c_brk: cover property (i_break_state && sc_wr && i_wb_dat[2]);
    c_level: cover property (mode_sh && o_cpu_request && !i_request_n);
endmodule
bind eil_top eil_sva chk_u (.*);

// *** sim/eil_pin_model.sv ***
// Behavioural external device driving the active-low request pin
`timescale 1ns/1ps
module eil_pin_model (
    // Clock
    input  wire logic i_clock,
    // Request pin toward the block
    output logic      o_request_n
);
    // Released line idles high
    initial o_request_n = 1'b1;
    // Change the level just after an edge
    task automatic drive(input logic lvl, input int unsigned dly);
        repeat (dly + 1) @(posedge i_clock);
        o_request_n <= lvl;
    endtask
endmodule

// *** sim/tb_external_interrupt_latch.sv ***
// Self-checking testbench of the external interrupt latch
`timescale 1ns/1ps
module tb_external_interrupt_latch;
    // Design stimulus and observation
    logic        clock;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [31:0] rdat;
    logic        ack;
    logic        pin_n;
    logic        vf;
    logic        gmask;
    logic        cpu_req;
    logic [15:0] vaddr;
    logic        brk;
    logic        bce;
    logic        irq;
    logic [31:0] r;
    // Reference model and counters
    int m_pend, m_wait, m_mask, m_mode, m_pin, m_ev, m_en;
    int bad_count, check_count;

    eil_top dut_u (
        .i_clock(clock), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_request_n(pin_n),
        .i_vector_fetch(vf), .i_global_mask(gmask), .o_cpu_request(cpu_req),
        .o_vector_addr(vaddr), .i_break_state(brk),
        .i_break_clear_enable(bce), .o_int(irq)
    );
    eil_pin_model pin_u (.i_clock(clock), .o_request_n(pin_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t out got=%h exp=%h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Bus cycles: hold the request until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] dd, input logic [3:0] s);
        int n;
        @(posedge clock);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, dd, s};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk_reg(r, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reference model of the latch
    task automatic clr;
        if (m_pend != 0) m_ev |= 2;
        m_pend = 0;
        m_wait = 0;
    endtask
    task automatic ackm(input bit sw);
        if (m_pend != 0 && !(sw && brk && !bce)) begin
            if (m_mode == 0 || m_pin != 0) clr();
            else m_wait = 1;
        end
    endtask
    task automatic wrs(input logic [7:0] a, input logic [31:0] dd,
                       input logic [3:0] s);
        wb(1'b1, a, dd, s);
        if (s[0]) begin
            case (a[7:2])
                6'h1a: begin
                    m_mask = dd[1];
                    if (!dd[0] && m_wait != 0) clr();
                    m_mode = dd[0];
                    if (dd[2]) ackm(1'b1);
                end
                6'h1b: m_ev &= ~int'(dd[1:0]);
                6'h1c: m_en = dd[1:0];
                default: ;
            endcase
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dd);
        wrs(a, dd, 4'h1);
    endtask
    task automatic pin(input logic lvl);
        pin_u.drive(lvl, $urandom_range(0, 3));
        repeat (4) @(posedge clock);
        m_pin = lvl;
        if (!lvl) begin
            m_pend = 1;
            m_ev |= 1;
        end else if (m_wait != 0) clr();
    endtask
    task automatic vfetch;
        @(posedge clock);
        vf <= 1'b1;
        @(posedge clock);
        vf <= 1'b0;
        ackm(1'b0);
    endtask
    // Compare the outputs and the status and event registers with the model
    task automatic verify;
        repeat (4) @(posedge clock);
        chk_out({15'h0, cpu_req}, 16'(m_pend != 0 && m_mask == 0 && !gmask));
        chk_out({15'h0, irq}, 16'((m_ev & m_en) != 0));
        chk_out(vaddr, 16'hfffa);
        rd_chk(8'h68, 32'(m_pend * 8 + m_mask * 2 + m_mode));
        rd_chk(8'h6c, 32'(m_ev));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, vf, gmask, brk, bce} = '0;
        {adr, wdat, sel} = '0;
        m_pin = 1;
        void'($urandom(40));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        verify();
        rd_chk(8'h70, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wrs({6'h1a, 2'(i)}, $urandom, 4'($urandom));
            verify();
        end
        wrs(8'h40, $urandom, 4'hf);
        rd_chk(8'h40, 32'h0);
        wr(8'h68, 32'h0);
        $display("test registers done");
        wr(8'h70, 32'h3);
        pin(1'b0);
        verify();
        vfetch();
        verify();
        wr(8'h6c, 32'h3);
        verify();
        pin(1'b1);
        pin(1'b0);
        wr(8'h68, 32'h4);
        verify();
        pin(1'b1);
        pin(1'b0);
        verify();
        $display("test edge done");
        wr(8'h68, 32'h2);
        verify();
        wr(8'h68, 32'h0);
        gmask <= 1'b1;
        verify();
        gmask <= 1'b0;
        verify();
        wr(8'h68, 32'h4);
        pin(1'b1);
        $display("test mask done");
        wr(8'h68, 32'h1);
        pin(1'b0);
        wr(8'h68, 32'h5);
        verify();
        pin(1'b1);
        verify();
        pin(1'b0);
        pin(1'b1);
        verify();
        vfetch();
        verify();
        pin(1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        {m_pend, m_wait, m_mask, m_mode, m_ev, m_en} = '0;
        verify();
        pin(1'b1);
        $display("test level done");
        wr(8'h70, 32'h3);
        pin(1'b0);
        pin(1'b1);
        brk <= 1'b1;
        wr(8'h68, 32'h4);
        verify();
        bce <= 1'b1;
        wr(8'h68, 32'h4);
        verify();
        {brk, bce} <= 2'b00;
        verify();
        wr(8'h70, 32'h0);
        verify();
        $display("test break done");
        print_verdict();
    end
endmodule
